//--- core/vdac_regs.sv
// APB register block for the eight voltage output channels and the controls of channels 6 and 7.
//
// Behaviour
// - Control bit 8 powers a channel down and floats its output, and it resets to 1.
// - While enable is 0 the channel's held code is cleared, one edge after the control write; when 1 the channel runs normally.
// - Range field bits 1:0 pick internal reference (00) or supply to ground (11); 01 and 10 are not to be written.
// - A write to the range field changes the channel's range at once.
// - Control bits 15:9 read as zero; bits 7:5 and 3:2 are writable, reset to zero, and steer nothing.
// - Each of the eight data registers holds a 12-bit read-write code in bits 27:16.
// - Data register bits 31:28 and 15:0 read as zero and software writes them as zero.
// - Every data register resets to all zeros.
`timescale 1ns/1ps
module vdac_regs (
  input  wire logic                                           SYS_CLK,
  input  wire logic                                           SRST,
  input  wire logic                                           PSEL,
  input  wire logic                                           PENABLE,
  input  wire logic                                           PWRITE,
  input  wire logic [vdac_pkg::ADDR_W-1:0]                    PADDR,
  input  wire logic [vdac_pkg::DATA_W-1:0]                    PWDATA,
  input  wire logic [vdac_pkg::STRB_W-1:0]                    PSTRB,
  output logic      [vdac_pkg::DATA_W-1:0]                    PRDATA,
  output logic                                                PREADY,
  output logic                                                PSLVERR,
  output logic      [vdac_pkg::CTL_CH-1:0]                    POWER_DOWN,
  output logic      [vdac_pkg::CTL_CH-1:0]                    CHAN_ENABLE,
  output logic      [2*vdac_pkg::CTL_CH-1:0]                  RANGE_SEL,
  output logic      [vdac_pkg::NUM_CH*vdac_pkg::CODE_W-1:0]   CODE_OUT
);

  import vdac_pkg::*;

  // Bus transfer phases, one-hot.
  // A transfer always takes three cycles: the setup cycle, one wait cycle and the answer cycle.
  // The wait cycle is there because the code store hands out its read word from a register,
  // so the word for the setup address is ready only one edge after the setup edge.
  // The answer cycle raises PREADY for exactly one cycle, and a write lands at the edge that
  // ends it, the one edge at which the master is sure to hold address, data and strobes.
  // The next setup may follow straight after the answer cycle.
  typedef enum logic [2:0] {
    BUS_IDLE    = 3'b001,
    BUS_FETCH   = 3'b010,
    BUS_RESPOND = 3'b100
  } bus_e;

  // All state of the block.
  // The read word, PREADY and PSLVERR are held here so that the bus outputs come
  // straight from flip-flops; the read word is zero outside the answer cycle.
  // The converter codes are registered too, which costs one cycle of latency on CODE_OUT.
  // Nothing outside this struct and the code store remembers anything.
  typedef struct packed {
    bus_e                                 st;
    logic [DATA_W-1:0]                    prdata;
    logic                                 pready;
    logic                                 pslverr;
    ctl_s [CTL_CH-1:0]                    ctl;
    logic [NUM_CH-1:0][CODE_W-1:0]        code_out;
  } state_s;

  // Reset image of the control bits.
  // Only bits 8 to 0 are stored, so the upper read-only bits cannot hold anything
  // that a later read would have to mask.
  localparam ctl_s CTL_RST = ctl_s'(CTL_RESET[CTL_STORED_W-1:0]);

  // Width of the index that picks one of the locally controlled channels.
  localparam int unsigned CTL_IW = $clog2(CTL_CH);

  // Reset image of the whole state.
  localparam state_s STATE_RST = '{
    st:       BUS_IDLE,
    prdata:   CODE_RESET,
    pready:   1'b0,
    pslverr:  1'b0,
    ctl:      {CTL_CH{CTL_RST}},
    code_out: '0
  };

  // Data register addresses in channel order.
  // The full 32-bit address is compared, so aliases of a register never answer
  // and reach the error response instead.
  // Entry 0 sits at the lowest bits of the packed array.
  localparam logic [NUM_CH-1:0][31:0] CODE_ADDR = {
    ANALOG_OUT7_CODE_ADDR,
    ANALOG_OUT6_CODE_ADDR,
    ANALOG_OUT5_CODE_ADDR,
    ANALOG_OUT4_CODE_ADDR,
    ANALOG_OUT3_CODE_ADDR,
    ANALOG_OUT2_CODE_ADDR,
    ANALOG_OUT1_CODE_ADDR,
    ANALOG_OUT0_CODE_ADDR
  };

  state_s state_r;
  state_s state_nxt;

  // Decoded view of the current bus address.
  dec_s dec;

  // Code store ports.
  logic                          store_wr_en;
  logic [CODE_W-1:0]             store_wr_data;
  logic [NUM_CH-1:0]             store_clr;
  logic [CODE_W-1:0]             store_rd_data;
  logic [NUM_CH*CODE_W-1:0]      store_words;
  logic [NUM_CH-1:0][CODE_W-1:0] held_code;

  // Bus access helpers.
  logic                          access;
  logic                          wr_hit;
  logic [CTL_IW-1:0]             ctl_idx;

  // Maps a bus address to a register; an address of no register gives hit low.
  // Reads, writes and the error response all use this one decode, so they agree
  // on which addresses exist.
  // The control addresses differ from every data address, so at most one register matches.
  function automatic dec_s decode(input logic [ADDR_W-1:0] addr);
    dec_s d;
    d = '0;
    if (addr == ANALOG_OUT6_CONTROL_ADDR)
    begin
      d.hit    = 1'b1;
      d.is_ctl = 1'b1;
      d.idx    = CH_AW'(CTL_BASE);
    end
    else if (addr == ANALOG_OUT7_CONTROL_ADDR)
    begin
      d.hit    = 1'b1;
      d.is_ctl = 1'b1;
      d.idx    = CH_AW'(CTL_BASE + 1);
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (addr == CODE_ADDR[i])
      begin
        d.hit = 1'b1;
        d.idx = CH_AW'(i);
      end
    end
    return d;
  endfunction : decode

  // Merges written byte lanes into the stored control bits.
  // Lane 0 carries bits 7 to 0 and lane 1 the power-down bit; the other lanes hold
  // only read-only bits, so their strobes are ignored.
  function automatic ctl_s merge_ctl(input ctl_s old, input logic [DATA_W-1:0] wdata,
                                     input logic [STRB_W-1:0] strb);
    logic [CTL_STORED_W-1:0] bits;
    bits = old;
    if (strb[0])
    begin
      bits[7:0] = wdata[7:0];
    end
    if (strb[1])
    begin
      bits[POWER_DOWN_BIT] = wdata[POWER_DOWN_BIT];
    end
    return ctl_s'(bits);
  endfunction : merge_ctl

  // Merges written byte lanes into a stored 12-bit code; bits outside the field are dropped.
  // Lane 2 carries code bits 7 to 0 and lane 3 code bits 11 to 8; the top nibble of lane 3
  // and lanes 0 and 1 are read-only and never reach the store.
  function automatic logic [CODE_W-1:0] merge_code(input logic [CODE_W-1:0] old,
                                                  input logic [DATA_W-1:0] wdata,
                                                  input logic [STRB_W-1:0] strb);
    logic [CODE_W-1:0] code;
    code = old;
    if (strb[2])
    begin
      code[7:0] = wdata[CODE_LSB +: 8];
    end
    if (strb[3])
    begin
      code[CODE_W-1:8] = wdata[CODE_LSB+8 +: CODE_W-8];
    end
    return code;
  endfunction : merge_code

  // Address decode and the completing access.
  // The access term is true only at the edge that ends the answer cycle, so a write can
  // never land twice, even while the master keeps its request up for a cycle too long.
  // The control index is cut to the width of the control array on purpose.
  assign dec     = decode(PADDR);
  assign access  = (state_r.st == BUS_RESPOND) && PSEL && PENABLE;
  assign wr_hit  = access && PWRITE && dec.hit;
  assign ctl_idx = CTL_IW'(dec.idx - CH_AW'(CTL_BASE));
  assign held_code = store_words;

  // Code writes go to the store at the edge that completes the transfer.
  // The write word merges into the held code, so a write with only one code lane enabled
  // keeps the other part of the code.
  assign store_wr_en   = wr_hit && !dec.is_ctl;
  assign store_wr_data = merge_code(held_code[dec.idx], PWDATA, PSTRB);

  // Channels without local controls are never cleared; 6 and 7 are cleared while disabled.
  // The clear is a level, not a pulse: a disabled channel keeps a zero code for as long as
  // it stays disabled, and a code written meanwhile is lost rather than kept for later.
  // Software must enable the channel first and write its code afterwards.
  // The clear follows the registered enable bit, one edge after the control write.
  always_comb
  begin
    store_clr = '0;
    for (int i = 0; i < CTL_CH; i++)
    begin
      store_clr[CTL_BASE + i] = !state_r.ctl[i].enable;
    end
  end

  // Storage of the eight output codes, all zero after reset.
  // The store reads and writes at the decoded channel; its read word is registered,
  // which is why the bus needs its wait cycle.
  // All words are also visible at once for the converter drive.
  code_store #(
    .WIDTH (CODE_W),
    .DEPTH (NUM_CH),
    .AW    (CH_AW)
  ) u_store (
    .clk     (SYS_CLK),
    .srst    (SRST),
    .wr_en   (store_wr_en),
    .wr_addr (dec.idx),
    .wr_data (store_wr_data),
    .clr     (store_clr),
    .rd_addr (dec.idx),
    .rd_data (store_rd_data),
    .words   (store_words)
  );

  // Next state: bus sequencing, control writes and converter drive.
  // Everything defaults to holding its value, so each branch below states only what changes.
  // The three parts read only registered state and bus inputs, never each other's next values.
  // That keeps the parts independent, so their order below does not matter.
  always_comb
  begin
    state_nxt = state_r;

    // Bus phases: setup starts a fetch, fetch loads the answer, respond completes it.
    // An unmapped address still gets its answer, with PSLVERR set and a zero read word,
    // so a stray access never hangs the bus.
    // The answer is held until the master completes the access phase.
    // A write answers with a zero read word as well.
    unique case (state_r.st)
      BUS_IDLE:
      begin
        state_nxt.pready  = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (PSEL && !PENABLE)
        begin
          state_nxt.st = BUS_FETCH;
        end
      end
      BUS_FETCH:
      begin
        state_nxt.st      = BUS_RESPOND;
        state_nxt.pready  = 1'b1;
        state_nxt.pslverr = !dec.hit;
        state_nxt.prdata  = '0;
        if (!PWRITE && dec.hit)
        begin
          if (dec.is_ctl)
          begin
            state_nxt.prdata[CTL_STORED_W-1:0] = state_r.ctl[ctl_idx];
          end
          else
          begin
            state_nxt.prdata[CODE_LSB +: CODE_W] = store_rd_data;
          end
        end
      end
      BUS_RESPOND:
      begin
        if (access)
        begin
          state_nxt.st      = BUS_IDLE;
          state_nxt.pready  = 1'b0;
          state_nxt.pslverr = 1'b0;
          state_nxt.prdata  = '0;
        end
      end
    endcase

    // Control writes land at the completing edge, range included, with no further trigger.
    // The new range reaches RANGE_SEL at that same edge, with no wait for a data write.
    // Reserved range codes are stored as written, since software is the side that must avoid them.
    if (wr_hit && dec.is_ctl)
    begin
      state_nxt.ctl[ctl_idx] = merge_ctl(state_r.ctl[ctl_idx], PWDATA, PSTRB);
    end

    // Converter codes: channels 6 and 7 pass their code only while enabled and powered up.
    // A powered-down channel keeps its stored code, so powering it up again brings the old
    // code back; a disabled channel has lost its code in the store.
    // Channels 0 to 5 have no controls here and always drive their stored code.
    // The drive follows the stored code one edge after the store changes.
    for (int i = 0; i < NUM_CH; i++)
    begin
      state_nxt.code_out[i] = held_code[i];
    end
    for (int i = 0; i < CTL_CH; i++)
    begin
      if (!state_r.ctl[i].enable || state_r.ctl[i].power_down_bit)
      begin
        state_nxt.code_out[CTL_BASE + i] = '0;
      end
    end
  end

  // State register with synchronous reset.
  // Reset puts channels 6 and 7 into power-down, every code to zero and the bus idle,
  // whatever transfer was in flight.
  // The code store is reset by the same line.
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      state_r <= STATE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register.
  // No logic stands between these flip-flops and the pins.
  // The read word is zero whenever PREADY is low.
  assign PRDATA   = state_r.prdata;
  assign PREADY   = state_r.pready;
  assign PSLVERR  = state_r.pslverr;
  assign CODE_OUT = state_r.code_out;

  // Per-channel control outputs for channels 6 and 7.
  // Bit 0 of POWER_DOWN and CHAN_ENABLE and bits 1 to 0 of RANGE_SEL belong to channel 6;
  // the next bit or pair belongs to channel 7.
  generate
    for (genvar g = 0; g < CTL_CH; g++)
    begin : g_ctl_out
      assign POWER_DOWN[g]       = state_r.ctl[g].power_down_bit;
      assign CHAN_ENABLE[g]      = state_r.ctl[g].enable;
      assign RANGE_SEL[2*g +: 2] = state_r.ctl[g].range_select;
    end
  endgenerate

endmodule : vdac_regs

//--- core/vdac_pkg.sv
// Shared constants and types for the voltage output register block.
package vdac_pkg;

  // Channel counts and widths.
  localparam int unsigned NUM_CH   = 8;
  localparam int unsigned CODE_W   = 12;
  localparam int unsigned CH_AW    = 3;
  localparam int unsigned CTL_CH   = 2;
  localparam int unsigned CTL_BASE = 6;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned STRB_W   = 4;

  // Control register byte addresses (channels 6 and 7).
  localparam logic [31:0] ANALOG_OUT6_CONTROL_ADDR = 32'h4008_2418;
  localparam logic [31:0] ANALOG_OUT7_CONTROL_ADDR = 32'h4008_241C;

  // Data register byte addresses (channels 0 to 7).
  localparam logic [31:0] ANALOG_OUT0_CODE_ADDR = 32'h4008_6404;
  localparam logic [31:0] ANALOG_OUT1_CODE_ADDR = 32'h4008_6408;
  localparam logic [31:0] ANALOG_OUT2_CODE_ADDR = 32'h4008_640C;
  localparam logic [31:0] ANALOG_OUT3_CODE_ADDR = 32'h4008_6410;
  localparam logic [31:0] ANALOG_OUT4_CODE_ADDR = 32'h4008_6414;
  localparam logic [31:0] ANALOG_OUT5_CODE_ADDR = 32'h4008_6418;
  localparam logic [31:0] ANALOG_OUT6_CODE_ADDR = 32'h4008_641C;
  localparam logic [31:0] ANALOG_OUT7_CODE_ADDR = 32'h4008_6420;

  // Control register field positions.
  localparam int unsigned RANGE_SELECT_LSB = 0;
  localparam int unsigned RSV_LO_LSB       = 2;
  localparam int unsigned ENABLE_BIT       = 4;
  localparam int unsigned RSV_HI_LSB       = 5;
  localparam int unsigned POWER_DOWN_BIT   = 8;
  localparam int unsigned CTL_STORED_W     = 9;

  // Data register field position.
  localparam int unsigned CODE_LSB = 16;

  // Range select encodings; the other two codes are reserved.
  localparam logic [1:0] RANGE_INTERNAL_REF = 2'h0;
  localparam logic [1:0] RANGE_SUPPLY       = 2'h3;

  // Reset values.
  localparam logic [15:0] CTL_RESET  = 16'h0100;
  localparam logic [31:0] CODE_RESET = 32'h0000_0000;

  // Stored control bits, laid out exactly as bits 8 to 0 of the register.
  typedef struct packed {
    logic       power_down_bit;
    logic [2:0] rsv_hi;
    logic       enable;
    logic [1:0] rsv_lo;
    logic [1:0] range_select;
  } ctl_s;

  // Result of an address decode.
  typedef struct packed {
    logic             hit;
    logic             is_ctl;
    logic [CH_AW-1:0] idx;
  } dec_s;

endpackage : vdac_pkg

//--- core/code_store.sv
// Small word store for the channel output codes, with clear lines and a registered read port.
`timescale 1ns/1ps
module code_store #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   wr_en,
  input  wire logic [AW-1:0]          wr_addr,
  input  wire logic [WIDTH-1:0]       wr_data,
  input  wire logic [DEPTH-1:0]       clr,
  input  wire logic [AW-1:0]          rd_addr,
  output logic      [WIDTH-1:0]       rd_data,
  output logic      [DEPTH*WIDTH-1:0] words
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd;
  } store_s;

  store_s store_r;
  store_s store_nxt;

  // A clear line beats a write to the same word in the same cycle.
  // The read word is taken after clears and writes, so a read set up in the cycle in which
  // a word is cleared already sees the zero.
  always_comb
  begin
    store_nxt = store_r;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (clr[i])
      begin
        store_nxt.mem[i] = '0;
      end
      else if (wr_en && (wr_addr == AW'(i)))
      begin
        store_nxt.mem[i] = wr_data;
      end
    end
    store_nxt.rd = store_nxt.mem[rd_addr];
  end

  // All words reset to zero.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      store_r <= '0;
    end
    else
    begin
      store_r <= store_nxt;
    end
  end

  // Every word is visible at once for the converters.
  assign rd_data = store_r.rd;
  assign words   = store_r.mem;

endmodule : code_store

//--- bench/vdac_regs_monitor.sv
// Checker that watches the ports of the voltage output register block.
`timescale 1ns/1ps
module vdac_regs_monitor (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [1:0]  POWER_DOWN,
  input wire logic [1:0]  CHAN_ENABLE,
  input wire logic [3:0]  RANGE_SEL,
  input wire logic [95:0] CODE_OUT
);
  import vdac_pkg::*;
  // All checks share the one clock and sleep while reset is high.
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // A transfer counts only at the edge where the slave answers.
  wire acc = PSEL & PENABLE & PREADY;
  wire rdc = acc & !PWRITE;
  property p_rst;
    $fell(SRST) |-> POWER_DOWN == 2'h3 && CHAN_ENABLE == 2'h0 && CODE_OUT == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_pd_wr;
    acc && PWRITE && PADDR == ANALOG_OUT6_CONTROL_ADDR && PSTRB[1] |=> POWER_DOWN[0] == $past(PWDATA[8]);
  endproperty
  a_pd_wr: assert property (p_pd_wr) else $error("power down not written");
  property p_rng;
    acc && PWRITE && PADDR == ANALOG_OUT7_CONTROL_ADDR && PSTRB[0] |=> RANGE_SEL[3:2] == $past(PWDATA[1:0]);
  endproperty
  a_rng: assert property (p_rng) else $error("range not applied at once");
  property p_clr;
    !CHAN_ENABLE[0] [*2] |-> CODE_OUT[83:72] == 12'h000;
  endproperty
  a_clr: assert property (p_clr) else $error("disabled code not cleared");
  property p_pd_out;
    POWER_DOWN[1] [*2] |-> CODE_OUT[95:84] == 12'h000;
  endproperty
  a_pd_out: assert property (p_pd_out) else $error("powered down code driven");
  property p_ctl_rd;
    rdc && (PADDR == ANALOG_OUT6_CONTROL_ADDR || PADDR == ANALOG_OUT7_CONTROL_ADDR) |-> PRDATA[31:9] == '0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control upper bits not zero");
  property p_dat_rd;
    rdc && PADDR[31:12] == 20'h40086 && !PSLVERR |-> PRDATA[31:28] == 4'h0 && PRDATA[15:0] == 16'h0000;
  endproperty
  a_dat_rd: assert property (p_dat_rd) else $error("code reserved bits not zero");
  property p_code;
    acc && PWRITE && PADDR == ANALOG_OUT0_CODE_ADDR && PSTRB == 4'hF |-> ##2 CODE_OUT[11:0] == $past(PWDATA[27:16], 2);
  endproperty
  a_code: assert property (p_code) else $error("code not driven out");
  property p_wait;
    PSEL && !PENABLE |=> !PREADY ##1 PREADY ##1 !PREADY;
  endproperty
  a_wait: assert property (p_wait) else $error("answer timing wrong");
  // Main scenarios that the bench should reach.
  c_ctl: cover property (acc && PWRITE && PADDR == ANALOG_OUT7_CONTROL_ADDR);
  c_err: cover property (PREADY && PSLVERR);
  c_clr: cover property ($fell(CHAN_ENABLE[0]));
endmodule : vdac_regs_monitor

bind vdac_regs vdac_regs_monitor i_mon (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .POWER_DOWN(POWER_DOWN), .CHAN_ENABLE(CHAN_ENABLE),
  .RANGE_SEL(RANGE_SEL), .CODE_OUT(CODE_OUT)
);

//--- bench/tb.sv
// Self-checking testbench for the voltage output register block.
`timescale 1ns/1ps
module tb;
  import vdac_pkg::*;
  logic        SYS_CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [31:0] PADDR = '0, PWDATA = '0, PRDATA;
  logic [3:0]  PSTRB = '0, RANGE_SEL;
  logic        PREADY, PSLVERR, er;
  logic [1:0]  POWER_DOWN, CHAN_ENABLE;
  logic [95:0] CODE_OUT;
  logic [31:0] rd;
  int          errors = 0, samples_checked = 0;

  vdac_regs i_dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_DOWN(POWER_DOWN),
    .CHAN_ENABLE(CHAN_ENABLE), .RANGE_SEL(RANGE_SEL), .CODE_OUT(CODE_OUT));

  // A 5 ns clock.
  always #2.5 SYS_CLK = ~SYS_CLK;

  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // One APB transfer; holds the request until the answer edge and takes data there.
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d; PSTRB <= s;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1 && ++n < 50);
    chk(PREADY, 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb

  task wt(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : wt

  // Reset values at the pins and through register reads.
  task t_reset;
    chk(POWER_DOWN, 2'h3);
    chk(CHAN_ENABLE, 2'h0);
    for (int c = 0; c < 2; c++)
    begin
      apb(0, ANALOG_OUT6_CONTROL_ADDR + 4 * c, 0, 0);
      chk(rd, CTL_RESET);
    end
    for (int i = 0; i < 8; i++)
    begin
      apb(0, ANALOG_OUT0_CODE_ADDR + 4 * i, 0, 0);
      chk(rd, CODE_RESET);
      chk(er, 1'b0);
      chk(CODE_OUT[12 * i +: 12], 12'h000);
    end
    $display("reset test done");
  endtask : t_reset

  // Codes with ones in the reserved bits; channels 6 and 7 are still disabled.
  task t_codes;
    logic [11:0] v;
    for (int i = 0; i < 8; i++)
      apb(1, ANALOG_OUT0_CODE_ADDR + 4 * i, {4'hF, 12'hA50 + 12'(i), 16'hFFFF}, 4'hF);
    wt(3);
    for (int i = 0; i < 8; i++)
    begin
      v = (i < 6) ? 12'hA50 + 12'(i) : 12'h000;
      apb(0, ANALOG_OUT0_CODE_ADDR + 4 * i, 0, 0);
      chk(rd, {4'h0, v, 16'h0000});
      chk(CODE_OUT[12 * i +: 12], v);
    end
    apb(1, ANALOG_OUT0_CODE_ADDR, 32'h0023_0000, 4'h4);
    apb(0, ANALOG_OUT0_CODE_ADDR, 0, 0);
    chk(rd, 32'h0A23_0000);
    apb(1, ANALOG_OUT0_CODE_ADDR, 32'h0B00_0000, 4'h8);
    apb(0, ANALOG_OUT0_CODE_ADDR, 0, 0);
    chk(rd, 32'h0B23_0000);
    wt(3);
    chk(CODE_OUT[11:0], 12'hB23);
    $display("code test done");
  endtask : t_codes

  // Control fields of channels 6 and 7 and their effect on the driven code.
  task t_ctl;
    logic [31:0] a, d;
    for (int c = 0; c < 2; c++)
    begin
      a = ANALOG_OUT6_CONTROL_ADDR + 4 * c;
      d = ANALOG_OUT6_CODE_ADDR + 4 * c;
      apb(1, a, 32'hFFFF_FFFF, 4'hF);
      apb(0, a, 0, 0);
      chk(rd, 32'h0000_01FF);
      apb(1, a, 32'h0000_0013, 4'hF);
      wt(1);
      chk(RANGE_SEL[2 * c +: 2], 2'h3);
      chk(POWER_DOWN[c], 1'b0);
      chk(CHAN_ENABLE[c], 1'b1);
      apb(1, d, 32'h0ABC_0000, 4'hF);
      wt(3);
      chk(CODE_OUT[12 * (6 + c) +: 12], 12'hABC);
      apb(1, a, 32'h0000_0010, 4'h1);
      wt(1);
      chk(RANGE_SEL[2 * c +: 2], 2'h0);
      apb(1, a, 32'h0000_0110, 4'hF);
      wt(3);
      chk(CODE_OUT[12 * (6 + c) +: 12], 12'h000);
      apb(0, d, 0, 0);
      chk(rd, 32'h0ABC_0000);
      apb(1, a, 32'h0000_0003, 4'h2);
      wt(3);
      chk(POWER_DOWN[c], 1'b0);
      chk(RANGE_SEL[2 * c +: 2], 2'h0);
      chk(CODE_OUT[12 * (6 + c) +: 12], 12'hABC);
      apb(1, a, 32'h0000_0000, 4'hF);
      wt(3);
      apb(0, d, 0, 0);
      chk(rd, 32'h0000_0000);
    end
    $display("control test done");
  endtask : t_ctl

  // An address between the registers answers with an error and zero data.
  task t_bad;
    apb(0, 32'h4008_6400, 0, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1, 32'h4008_6400, 32'h0FFF_0000, 4'hF);
    chk(er, 1'b1);
    $display("unmapped test done");
  endtask : t_bad

  task final_report;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Main sequence, with a second reset in mid-run.
  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    SRST <= 0;
    wt(1);
    t_reset;
    t_codes;
    t_ctl;
    t_bad;
    @(posedge SYS_CLK);
    SRST <= 1;
    repeat (12) @(posedge SYS_CLK);
    SRST <= 0;
    wt(1);
    t_reset;
    final_report;
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    #100us;
    errors++;
    final_report;
  end
endmodule : tb
